// File: rops_top.sv
// registered output stage with preload, power-up clear and secured readback
`timescale 1ns/1ps
`default_nettype none
module rops_top #(
  parameter int unsigned WIDTH = rops_pkg::REG_WIDTH,
  parameter int unsigned ARRAY_BITS = rops_pkg::ARRAY_BITS,
  parameter int unsigned AW = $clog2(ARRAY_BITS)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] next_state,
  input wire logic out_en_n,
  input wire logic preload_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] state_fb,
  output logic por_busy,
  input wire logic fuse_prog_en,
  input wire logic [AW-1:0] fuse_addr,
  input wire logic fuse_wdata,
  input wire logic secure_blow,
  input wire logic rd_req,
  output logic rd_valid,
  output logic rd_bit,
  output logic secured
);
  localparam logic [WIDTH-1:0] RESET_VEC = WIDTH'(rops_pkg::REG_RESET);

  typedef enum logic [1:0] {
    MODE_CLEAR = 2'b00,
    MODE_LOAD = 2'b01,
    MODE_RUN = 2'b10
  } rops_mode_t;

  rops_mode_t mode;
  logic drive_en;
  logic [WIDTH-1:0] state_d;
  logic [WIDTH-1:0] state_q;
  logic [WIDTH-1:0] pin_q;
  logic fuse_q [ARRAY_BITS];
  logic fuse_we;
  logic secure_q;
  logic rd_src;
  rops_pkg::rops_rdback_t rdback_q;

  rops_por #(
    .CYCLES(rops_pkg::POR_CYCLES)
  ) u_por (
    .ref_clk(ref_clk),
    .reset(reset),
    .por_busy(por_busy)
  );

  // clear held through delay
  // edges inside the delay load the clear value, so early clocks do no harm
  always_comb begin
    if (reset || por_busy) begin
      mode = MODE_CLEAR;
    end else if (preload_en) begin
      mode = MODE_LOAD;
    end else begin
      mode = MODE_RUN;
    end
  end

  // preload disables drivers
  // drivers stay off during preload so the tester never fights the device
  assign drive_en = ~out_en_n & ~preload_en & ~por_busy;

  // one capture cell per registered output
  for (genvar gi = 0; gi < WIDTH; gi++) begin : g_cell
    always_comb begin
      case (mode)
        MODE_CLEAR: begin
          state_d[gi] = RESET_VEC[gi];
        end
        MODE_LOAD: begin
          // load from pins
          // pins are active low, so the stored bit is the inverted pin level
          state_d[gi] = ~pin_in[gi];
        end
        MODE_RUN: begin
          state_d[gi] = next_state[gi];
        end
        default: begin
          state_d[gi] = RESET_VEC[gi];
        end
      endcase
    end

    always_ff @(posedge ref_clk) begin
      state_q[gi] <= state_d[gi];
    end

    // inverted output value
    // pin level has its own flop so the output never passes through logic
    always_ff @(posedge ref_clk) begin
      pin_q[gi] <= ~state_d[gi];
    end

    assign pin_oe[gi] = drive_en;
  end

  assign state_fb = state_q;
  assign pin_out = pin_q;

  // writes refused once secured
  assign fuse_we = fuse_prog_en & ~secure_q & fuse_wdata;

  // one cell per fuse; programming only ever sets a cell, never restores it
  for (genvar gf = 0; gf < ARRAY_BITS; gf++) begin : g_fuse
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        fuse_q[gf] <= 1'b0;
      end else if (fuse_we && (fuse_addr == AW'(gf))) begin
        fuse_q[gf] <= 1'b1;
      end
    end
  end

  // security fuse is sticky: only reset clears it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      secure_q <= 1'b0;
    end else if (secure_blow) begin
      secure_q <= 1'b1;
    end
  end

  assign secured = secure_q;

  assign rd_src = secure_q ? rops_pkg::FUSE_PROGRAMMED_BIT : fuse_q[fuse_addr];

  // answer flag follows the request one cycle later, high for as long as the request is held
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdback_q.rd_valid <= 1'b0;
    end else begin
      rdback_q.rd_valid <= rd_req;
    end
  end

  // read bit holds until the next request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdback_q.rd_bit <= 1'b0;
    end else if (rd_req) begin
      rdback_q.rd_bit <= rd_src;
    end
  end

  assign rd_valid = rdback_q.rd_valid;
  assign rd_bit = rdback_q.rd_bit;
endmodule // rops_top
`default_nettype wire

// File: rops_pkg.sv
// shared constants and carrier types for the registered output stage
`default_nettype none
package rops_pkg;
  localparam int unsigned REG_WIDTH = 8;
  localparam int unsigned ARRAY_BITS = 2048;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POR_TIME_NS = 1000;
  // longest time: round down, at least one cycle
  localparam int unsigned POR_CYCLES_RAW = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned POR_CYCLES = (POR_CYCLES_RAW < 1) ? 1 : POR_CYCLES_RAW;
  localparam logic [REG_WIDTH-1:0] REG_RESET = 8'h00;
  localparam logic FUSE_PROGRAMMED_BIT = 1'b1;

  typedef struct packed {
    logic [REG_WIDTH-1:0] pin_out;
    logic [REG_WIDTH-1:0] pin_oe;
  } rops_pins_t;

  typedef struct packed {
    logic rd_valid;
    logic rd_bit;
  } rops_rdback_t;
endpackage : rops_pkg
`default_nettype wire

// File: rops_por.sv
// power-up reset sequencer: holds clear until the reset delay has elapsed
`timescale 1ns/1ps
`default_nettype none
module rops_por #(
  parameter int unsigned CYCLES = rops_pkg::POR_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  output logic por_busy
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(CYCLES)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // clear is finished once the count reaches the delay
  assign por_busy = (cnt_q != CW'(CYCLES));
endmodule // rops_por
`default_nettype wire

// File: rops_props.sv
// checker for the registered output stage
`timescale 1ns/1ps
`default_nettype none
module rops_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic out_en_n,
  input wire logic preload_en,
  input wire logic por_busy,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic rd_bit,
  input wire logic secured,
  input wire logic [7:0] next_state,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] state_fb,
  input wire logic [7:0] pin_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_pin_inv: assert property (pin_out == ~state_fb) else $error("inv");
  a_d_load: assert property (!por_busy && !preload_en |=> state_fb == $past(next_state))
    else $error("load");
  a_pre_take: assert property (preload_en && !por_busy |=> state_fb == ~$past(pin_in))
    else $error("pre");
  a_oe_all: assert property (pin_oe == {8{!(out_en_n | preload_en | por_busy)}})
    else $error("oe");
  a_por_zero: assert property (por_busy |-> !state_fb) else $error("clr");
  a_por_end: assert property ($fell(reset) |-> ##[1:101] !por_busy) else $error("por");
  a_rd_pulse: assert property (rd_valid == $past(rd_req)) else $error("rdv");
  a_sec_one: assert property (secured && rd_req |=> rd_bit) else $error("sec");
  cover property (preload_en && !por_busy);
  cover property (secured && rd_req);
  cover property ($fell(por_busy));
  cover property ($fell(reset));
endmodule // rops_chk
bind rops_top rops_chk chk_u (.*);
`default_nettype wire

// File: rops_tester.sv
// tester model: drives the pins only while device drivers are off
`timescale 1ns/1ps
`default_nettype none
module rops_tester (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] drv,
  output logic [7:0] pin_in
);
  assign pin_in = pin_oe[0] ? pin_out : drv;
endmodule // rops_tester
`default_nettype wire

// File: test_rops_top.sv
// bench for the registered output stage
`timescale 1ns/1ps
`default_nettype none
module test_rops_top;
  logic ref_clk = 0, reset = 1, out_en_n = 0, preload_en = 0, rd_req = 0, fuse_prog_en = 0;
  logic fuse_wdata = 1, secure_blow = 0, por_busy, rd_valid, rd_bit, secured;
  logic [7:0] next_state = 8'h77, drv = 8'ha5, pin_in, pin_out, pin_oe, state_fb;
  logic [10:0] fuse_addr = 11'h005;
  int n_fail = 0, cmp_count = 0;
  rops_tester tst_u (
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .drv(drv),
    .pin_in(pin_in)
  );
  rops_top dut_u (
    .ref_clk(ref_clk),
    .reset(reset),
    .next_state(next_state),
    .out_en_n(out_en_n),
    .preload_en(preload_en),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .state_fb(state_fb),
    .por_busy(por_busy),
    .fuse_prog_en(fuse_prog_en),
    .fuse_addr(fuse_addr),
    .fuse_wdata(fuse_wdata),
    .secure_blow(secure_blow),
    .rd_req(rd_req),
    .rd_valid(rd_valid),
    .rd_bit(rd_bit),
    .secured(secured)
  );
  initial forever #5 ref_clk = ~ref_clk;
  task cy(int n); repeat (n) @(negedge ref_clk); endtask
  task ck(logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin n_fail++; $display("Error %0t %h %h", $time, g, e); end
  endtask
  task results;
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the power-up clear to finish
  task wait_por;
    for (int i = 0; i < 101 && por_busy !== 1'b0; i++) cy(1);
    ck({7'h00, por_busy}, 8'h00);
    if (por_busy !== 1'b0) results;
  endtask
  task t_por;
    ck(pin_out, 8'hff);
    ck(state_fb, 8'h00);
    wait_por;
    ck(state_fb, 8'h00);
    $display("power-up test done");
  endtask
  task t_pre;
    preload_en = 1; cy(1);
    ck(state_fb, 8'h5a);
    ck(pin_out, 8'ha5);
    ck(pin_oe, 8'h00);
    preload_en = 0; next_state = 8'hc3; cy(1);
    ck(state_fb, 8'hc3);
    ck(pin_out, 8'h3c);
    ck(pin_oe, 8'hff);
    $display("preload test done");
  endtask
  task t_rd;
    out_en_n = 1; fuse_prog_en = 1; cy(1);
    ck(pin_oe, 8'h00);
    fuse_prog_en = 0; rd_req = 1; cy(1);
    ck({6'h00, rd_valid, rd_bit}, 8'h03);
    fuse_addr = 11'h006; cy(1);
    ck({6'h00, rd_valid, rd_bit}, 8'h02);
    // secured flag lands one edge before the read that sees it
    secure_blow = 1; cy(2);
    ck({7'h00, secured}, 8'h01);
    ck({6'h00, rd_valid, rd_bit}, 8'h03);
    fuse_addr = 11'h007; cy(1);
    ck({6'h00, rd_valid, rd_bit}, 8'h03);
    rd_req = 0; cy(1);
    ck({6'h00, rd_valid, rd_bit}, 8'h01);
    $display("readback test done");
  endtask
  // mid-run reset: everything clears and the power-up delay runs again
  task t_rst;
    reset = 1; rd_req = 0; secure_blow = 0; out_en_n = 0; cy(1);
    ck(state_fb, 8'h00);
    ck({6'h00, secured, rd_valid}, 8'h00);
    reset = 0; cy(1);
    ck(pin_out, 8'hff);
    ck({7'h00, por_busy}, 8'h01);
    wait_por;
    ck(state_fb, 8'h00);
    ck(pin_oe, 8'hff);
    $display("reset test done");
  endtask
  initial begin
    cy(4); reset = 0; cy(1);
    t_por; t_pre; t_rd; t_rst;
    results;
  end
endmodule // test_rops_top
`default_nettype wire
